// ### logic/icyc_timing.sv
// Instruction cycle timing model: computes clocks and bus cycles per request.
// Assumes requests from same-clock logic; wait_clks counts memory wait states.
`default_nettype none

module icyc_timing (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire icyc_pkg::icyc_req_s req,
  input  wire logic [7:0]          wait_clks,
  output logic                     resp_valid,
  output var  icyc_pkg::icyc_resp_s resp_r
);

  // -----------------------------------------------------------------------
  // Request capture
  // -----------------------------------------------------------------------
  icyc_pkg::icyc_st_e   st_r;
  icyc_pkg::icyc_req_s  req_r;
  logic [7:0]           wait_r;
  icyc_pkg::icyc_cost_s src_cost;
  icyc_pkg::icyc_cost_s dst_cost;

  assign req_ready  = (st_r == icyc_pkg::ICYC_ST_IDLE);
  assign resp_valid = (st_r == icyc_pkg::ICYC_ST_DONE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= icyc_pkg::ICYC_ST_IDLE;
    end else begin
      case (st_r)
        icyc_pkg::ICYC_ST_IDLE: begin
          if (req_valid) begin
            st_r <= icyc_pkg::ICYC_ST_RUN;
          end
        end
        icyc_pkg::ICYC_ST_RUN:  st_r <= icyc_pkg::ICYC_ST_DONE;
        default:                st_r <= icyc_pkg::ICYC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_r  <= '0;
      wait_r <= 8'h00;
    end else if (req_valid && req_ready) begin
      req_r  <= req;
      wait_r <= wait_clks;
    end
  end

  // The lookups read the request on the edge that takes it, so that their
  // registered costs are ready in the run state; feeding them from the
  // captured copy would leave them one request behind.
  // A destination address never depends on the operand size, and a
  // predecrement destination costs no more than a plain indirect one.
  icyc_pkg::icyc_ea_e dst_mode;

  assign dst_mode = (req.dst == icyc_pkg::ICYC_EA_PRE) ? icyc_pkg::ICYC_EA_IND : req.dst;

  icyc_ea_cost u_src (
    .clk_sys (clk_sys),
    .rst     (rst),
    .mode    (req.src),
    .is_long (req.is_long),
    .cost_r  (src_cost)
  );

  icyc_ea_cost u_dst (
    .clk_sys (clk_sys),
    .rst     (rst),
    .mode    (dst_mode),
    .is_long (1'b0),
    .cost_r  (dst_cost)
  );

  // -----------------------------------------------------------------------
  // Multiply operand bit count
  // -----------------------------------------------------------------------
  logic [16:0] mul_ext;
  logic [15:0] bit_hit;
  logic [4:0]  mul_n;

  assign mul_ext = {req_r.operand, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_bits
      assign bit_hit[gi] = (req_r.op == icyc_pkg::ICYC_OP_SIGNED_MULTIPLY)
                           ? (mul_ext[gi+1] ^ mul_ext[gi])
                           : req_r.operand[gi];
    end
  endgenerate

  always_comb begin
    mul_n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      mul_n = mul_n + 5'(bit_hit[i]);
    end
  end

  // -----------------------------------------------------------------------
  // Cost assembly
  // -----------------------------------------------------------------------
  icyc_pkg::icyc_cost_s base;
  icyc_pkg::icyc_cost_s total;
  logic                 add_ea;
  logic                 illegal;
  logic                 src_reg;
  logic                 dst_reg;
  logic [7:0]           div_dep;

  assign src_reg = (req_r.src == icyc_pkg::ICYC_EA_DREG) ||
                   (req_r.src == icyc_pkg::ICYC_EA_AREG);
  assign dst_reg = (req_r.dst == icyc_pkg::ICYC_EA_DREG) ||
                   (req_r.dst == icyc_pkg::ICYC_EA_AREG);
  // Divide time varies only a little with the low operand bits.
  assign div_dep = {4'h0, req_r.operand[3:0]};

  always_comb begin
    base        = '0;
    base.reads  = icyc_pkg::R_ONE;
    base.writes = icyc_pkg::B_ZERO;
    add_ea      = 1'b1;
    illegal     = 1'b0;
    case (req_r.op)
      icyc_pkg::ICYC_OP_MOVE: begin
        base.clks = icyc_pkg::C_MOVE_RR;
        if (!dst_reg) begin
          base.clks   = base.clks + (req_r.is_long ? icyc_pkg::C_WR_MEM_L
                                                   : icyc_pkg::C_WR_MEM_BW);
          base.writes = req_r.is_long ? icyc_pkg::W_TWO : icyc_pkg::W_ONE;
        end
      end
      icyc_pkg::ICYC_OP_ADD, icyc_pkg::ICYC_OP_SUB,
      icyc_pkg::ICYC_OP_AND, icyc_pkg::ICYC_OP_OR,
      icyc_pkg::ICYC_OP_CMP: begin
        if (req_r.dkind == icyc_pkg::ICYC_DST_MEM) begin
          base.clks   = req_r.is_long ? icyc_pkg::C_MEM_L : icyc_pkg::C_MEM_BW;
          base.writes = req_r.is_long ? icyc_pkg::W_TWO : icyc_pkg::W_ONE;
          illegal     = (req_r.op == icyc_pkg::ICYC_OP_CMP);
        end else if (req_r.is_long) begin
          base.clks = icyc_pkg::C_STD_L;
          if ((src_reg || req_r.src == icyc_pkg::ICYC_EA_IMM) &&
              req_r.op != icyc_pkg::ICYC_OP_CMP) begin
            base.clks = icyc_pkg::C_STD_L_RR;
            add_ea    = 1'b0;
          end
        end else if (req_r.dkind == icyc_pkg::ICYC_DST_AREG) begin
          base.clks = (req_r.op == icyc_pkg::ICYC_OP_CMP) ? icyc_pkg::C_CMP_AN
                                                          : icyc_pkg::C_ADD_AN_BW;
        end else begin
          base.clks = icyc_pkg::C_STD_BW;
        end
      end
      icyc_pkg::ICYC_OP_EOR: begin
        if (req_r.dkind == icyc_pkg::ICYC_DST_MEM) begin
          base.clks   = req_r.is_long ? icyc_pkg::C_MEM_L : icyc_pkg::C_MEM_BW;
          base.writes = req_r.is_long ? icyc_pkg::W_TWO : icyc_pkg::W_ONE;
        end else begin
          base.clks = req_r.is_long ? icyc_pkg::C_EOR_L : icyc_pkg::C_EOR_BW;
          add_ea    = 1'b0;
          illegal   = (req_r.src != icyc_pkg::ICYC_EA_DREG);
        end
      end
      icyc_pkg::ICYC_OP_UNSIGNED_MULTIPLY, icyc_pkg::ICYC_OP_SIGNED_MULTIPLY: begin
        base.clks = icyc_pkg::C_MUL_BASE + icyc_pkg::icyc_clk_t'({mul_n, 1'b0});
      end
      icyc_pkg::ICYC_OP_SIGNED_DIVIDE: begin
        base.clks = icyc_pkg::C_SIGNED_DIVIDE_MAX - icyc_pkg::C_SIGNED_DIVIDE_SPAN
                    + (div_dep < icyc_pkg::C_SIGNED_DIVIDE_SPAN ? div_dep : icyc_pkg::C_SIGNED_DIVIDE_SPAN);
      end
      icyc_pkg::ICYC_OP_UNSIGNED_DIVIDE: begin
        base.clks = icyc_pkg::C_UNSIGNED_DIVIDE_MAX - icyc_pkg::C_UNSIGNED_DIVIDE_SPAN
                    + (div_dep < icyc_pkg::C_UNSIGNED_DIVIDE_SPAN ? div_dep : icyc_pkg::C_UNSIGNED_DIVIDE_SPAN);
      end
      icyc_pkg::ICYC_OP_CLR, icyc_pkg::ICYC_OP_NOT: begin
        if (src_reg) begin
          base.clks = req_r.is_long ? icyc_pkg::C_CLR_L : icyc_pkg::C_STD_BW;
        end else begin
          base.clks   = req_r.is_long ? icyc_pkg::C_MEM_L : icyc_pkg::C_MEM_BW;
          base.writes = req_r.is_long ? icyc_pkg::W_TWO : icyc_pkg::W_ONE;
        end
      end
      icyc_pkg::ICYC_OP_TST: begin
        base.clks = icyc_pkg::C_STD_BW;
      end
      default: begin
        illegal = 1'b1;
      end
    endcase
  end

  always_comb begin
    total = base;
    if (add_ea) begin
      total.clks  = base.clks + src_cost.clks;
      total.reads = base.reads + src_cost.reads;
    end
    if (req_r.op == icyc_pkg::ICYC_OP_MOVE && !dst_reg) begin
      total.clks  = total.clks + dst_cost.clks
                    - (dst_cost.reads != 3'h0 ? icyc_pkg::BUS_CYC_W : 8'h00);
      total.reads = total.reads + dst_cost.reads
                    - (dst_cost.reads != 3'h0 ? icyc_pkg::R_ONE : 3'h0);
    end
    total.clks = total.clks + wait_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_r <= '0;
    end else if (st_r == icyc_pkg::ICYC_ST_RUN) begin
      resp_r.cost    <= total;
      resp_r.illegal <= illegal;
    end
  end

endmodule : icyc_timing

`default_nettype wire

// ### logic/icyc_pkg.sv
// Constants, types and mode codes for the instruction cycle timing block.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
`default_nettype none

package icyc_pkg;

  // ---------------------------------------------------------------------
  // Clock and bus timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned BUS_CYC_CLKS  = 4;
  localparam logic [7:0]  BUS_CYC_W     = 8'h04;

  localparam int CW = 8;  // clock count width
  localparam int BW = 3;  // bus cycle count width

  typedef logic [CW-1:0] icyc_clk_t;
  typedef logic [BW-1:0] icyc_bus_t;

  // ---------------------------------------------------------------------
  // Addressing modes
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ICYC_EA_DREG  = 4'h0,
    ICYC_EA_AREG  = 4'h1,
    ICYC_EA_IND   = 4'h2,
    ICYC_EA_POST  = 4'h3,
    ICYC_EA_PRE   = 4'h4,
    ICYC_EA_DISP  = 4'h5,
    ICYC_EA_INDEX = 4'h6,
    ICYC_EA_ABSW  = 4'h7,
    ICYC_EA_ABSL  = 4'h8,
    ICYC_EA_PCD   = 4'h9,
    ICYC_EA_PCX   = 4'ha,
    ICYC_EA_IMM   = 4'hb
  } icyc_ea_e;

  // Instruction classes covered by the block.
  typedef enum logic [3:0] {
    ICYC_OP_MOVE  = 4'h0,
    ICYC_OP_ADD   = 4'h1,
    ICYC_OP_SUB   = 4'h2,
    ICYC_OP_AND   = 4'h3,
    ICYC_OP_OR    = 4'h4,
    ICYC_OP_CMP   = 4'h5,
    ICYC_OP_EOR   = 4'h6,
    ICYC_OP_UNSIGNED_MULTIPLY  = 4'h7,
    ICYC_OP_SIGNED_MULTIPLY  = 4'h8,
    ICYC_OP_UNSIGNED_DIVIDE  = 4'h9,
    ICYC_OP_SIGNED_DIVIDE  = 4'ha,
    ICYC_OP_CLR   = 4'hb,
    ICYC_OP_NOT   = 4'hc,
    ICYC_OP_TST   = 4'hd
  } icyc_op_e;

  // Destination kind for standard instructions.
  typedef enum logic [1:0] {
    ICYC_DST_AREG = 2'h0,
    ICYC_DST_DREG = 2'h1,
    ICYC_DST_MEM  = 2'h2
  } icyc_dst_e;

  // Sequencer states, Gray along idle -> run -> done.
  typedef enum logic [1:0] {
    ICYC_ST_IDLE = 2'b00,
    ICYC_ST_RUN  = 2'b01,
    ICYC_ST_DONE = 2'b11
  } icyc_st_e;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    icyc_op_e     op;
    logic         is_long;
    icyc_ea_e     src;
    icyc_ea_e     dst;
    icyc_dst_e    dkind;
    logic [15:0]  operand;
  } icyc_req_s;

  typedef struct packed {
    icyc_clk_t clks;
    icyc_bus_t reads;
    icyc_bus_t writes;
  } icyc_cost_s;

  typedef struct packed {
    icyc_cost_s cost;
    logic       illegal;
  } icyc_resp_s;

  // ---------------------------------------------------------------------
  // Fixed figures
  // ---------------------------------------------------------------------
  localparam icyc_clk_t C_MOVE_RR   = 8'h04;
  localparam icyc_clk_t C_STD_BW    = 8'h04;
  localparam icyc_clk_t C_STD_L     = 8'h06;
  localparam icyc_clk_t C_STD_L_RR  = 8'h08;
  localparam icyc_clk_t C_ADD_AN_BW = 8'h08;
  localparam icyc_clk_t C_CMP_AN    = 8'h06;
  localparam icyc_clk_t C_MEM_BW    = 8'h08;
  localparam icyc_clk_t C_MEM_L     = 8'h0c;
  localparam icyc_clk_t C_EOR_BW    = 8'h04;
  localparam icyc_clk_t C_EOR_L     = 8'h08;
  localparam icyc_clk_t C_MUL_BASE  = 8'h26;
  localparam icyc_clk_t C_MUL_MAX   = 8'h46;
  localparam icyc_clk_t C_SIGNED_DIVIDE_MAX  = 8'h9e;
  localparam icyc_clk_t C_UNSIGNED_DIVIDE_MAX  = 8'h8c;
  // Divider spread kept under a tenth of the worst case.
  localparam icyc_clk_t C_SIGNED_DIVIDE_SPAN = 8'h0f;
  localparam icyc_clk_t C_UNSIGNED_DIVIDE_SPAN = 8'h0d;
  localparam icyc_clk_t C_CLR_L     = 8'h06;
  localparam icyc_clk_t C_WR_MEM_BW = 8'h04;
  localparam icyc_clk_t C_WR_MEM_L  = 8'h08;
  localparam icyc_bus_t R_ONE       = 3'h1;
  localparam icyc_bus_t W_ONE       = 3'h1;
  localparam icyc_bus_t W_TWO       = 3'h2;
  localparam icyc_bus_t B_ZERO      = 3'h0;
  localparam int        MUL_SHIFT   = 1;

endpackage : icyc_pkg

`default_nettype wire

// ### logic/icyc_ea_cost.sv
// Effective-address cost lookup: clocks and reads for one operand.
// Assumes mode and size come from same-clock logic; result is registered.
`default_nettype none

module icyc_ea_cost (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire icyc_pkg::icyc_ea_e mode,
  input  wire logic               is_long,
  output var  icyc_pkg::icyc_cost_s cost_r
);

  icyc_pkg::icyc_cost_s cost_nxt;

  always_comb begin
    cost_nxt = '0;
    cost_nxt.writes = icyc_pkg::B_ZERO;
    case (mode)
      icyc_pkg::ICYC_EA_DREG,
      icyc_pkg::ICYC_EA_AREG: begin
        cost_nxt.clks  = 8'h00;
        cost_nxt.reads = 3'h0;
      end
      icyc_pkg::ICYC_EA_IND,
      icyc_pkg::ICYC_EA_POST,
      icyc_pkg::ICYC_EA_IMM: begin
        cost_nxt.clks  = is_long ? 8'h08 : 8'h04;
        cost_nxt.reads = is_long ? 3'h2 : 3'h1;
      end
      icyc_pkg::ICYC_EA_PRE: begin
        cost_nxt.clks  = is_long ? 8'h0a : 8'h06;
        cost_nxt.reads = is_long ? 3'h2 : 3'h1;
      end
      icyc_pkg::ICYC_EA_DISP,
      icyc_pkg::ICYC_EA_PCD,
      icyc_pkg::ICYC_EA_ABSW: begin
        cost_nxt.clks  = is_long ? 8'h0c : 8'h08;
        cost_nxt.reads = is_long ? 3'h3 : 3'h2;
      end
      icyc_pkg::ICYC_EA_INDEX,
      icyc_pkg::ICYC_EA_PCX: begin
        cost_nxt.clks  = is_long ? 8'h0e : 8'h0a;
        cost_nxt.reads = is_long ? 3'h3 : 3'h2;
      end
      icyc_pkg::ICYC_EA_ABSL: begin
        cost_nxt.clks  = is_long ? 8'h10 : 8'h0c;
        cost_nxt.reads = is_long ? 3'h4 : 3'h3;
      end
      default: begin
        cost_nxt.clks  = 8'h00;
        cost_nxt.reads = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cost_r <= '0;
    end else begin
      cost_r <= cost_nxt;
    end
  end

endmodule : icyc_ea_cost

`default_nettype wire

// ### testbench/icyc_timing_props.sv
// Concurrent checks on the ports of the instruction cycle timing block.
// Assumes one clock domain; bound to the design top at the foot of this file.
`default_nettype none

module icyc_timing_props (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire logic                 req_valid,
  input wire logic                 req_ready,
  input wire icyc_pkg::icyc_req_s  req,
  input wire logic [7:0]           wait_clks,
  input wire logic                 resp_valid,
  input wire icyc_pkg::icyc_resp_s resp_r
);
  // ---------------------------------------------------------------------
  // Capture of the request that was taken
  // ---------------------------------------------------------------------
  icyc_pkg::icyc_req_s c_r;
  logic [7:0]          w_r;
  logic                src_rr;
  logic                dst_rr;
  icyc_pkg::icyc_clk_t net;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c_r <= '0;
      w_r <= 8'h00;
    end else if (req_valid && req_ready) begin
      c_r <= req;
      w_r <= wait_clks;
    end
  end

  assign src_rr = c_r.src == icyc_pkg::ICYC_EA_DREG || c_r.src == icyc_pkg::ICYC_EA_AREG;
  assign dst_rr = c_r.dst == icyc_pkg::ICYC_EA_DREG || c_r.dst == icyc_pkg::ICYC_EA_AREG;
  // Wait clocks are removed so that the fixed figures can be compared.
  assign net = resp_r.cost.clks - w_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  property p_move_rr;
    resp_valid && c_r.op == icyc_pkg::ICYC_OP_MOVE && src_rr && dst_rr
      |-> net == 8'h04 && resp_r.cost.reads == 3'h1 && resp_r.cost.writes == 3'h0;
  endproperty
  a_move_rr: assert property (p_move_rr) else $error("move between registers cost wrong");

  property p_no_write;
    resp_valid && c_r.dkind != icyc_pkg::ICYC_DST_MEM && c_r.op inside {icyc_pkg::ICYC_OP_ADD,
      icyc_pkg::ICYC_OP_SUB, icyc_pkg::ICYC_OP_AND, icyc_pkg::ICYC_OP_OR, icyc_pkg::ICYC_OP_UNSIGNED_MULTIPLY}
      |-> resp_r.cost.writes == 3'h0;
  endproperty
  a_no_write: assert property (p_no_write) else $error("register result shows a write");

  property p_reg_src;
    resp_valid && c_r.op == icyc_pkg::ICYC_OP_ADD && !c_r.is_long && src_rr
      && c_r.dkind == icyc_pkg::ICYC_DST_DREG |-> net == 8'h04 && resp_r.cost.reads == 3'h1;
  endproperty
  a_reg_src: assert property (p_reg_src) else $error("register operand added cost");

  property p_long_rr;
    resp_valid && c_r.is_long && src_rr && c_r.dkind == icyc_pkg::ICYC_DST_DREG && c_r.op inside
      {icyc_pkg::ICYC_OP_ADD, icyc_pkg::ICYC_OP_SUB, icyc_pkg::ICYC_OP_AND, icyc_pkg::ICYC_OP_OR}
      |-> net == 8'h08;
  endproperty
  a_long_rr: assert property (p_long_rr) else $error("long register operation not 8");

  property p_eor;
    resp_valid && c_r.op == icyc_pkg::ICYC_OP_EOR && c_r.dkind == icyc_pkg::ICYC_DST_DREG
      |-> (c_r.src != icyc_pkg::ICYC_EA_DREG) ? resp_r.illegal
        : (!resp_r.illegal && net == (c_r.is_long ? 8'h08 : 8'h04));
  endproperty
  a_eor: assert property (p_eor) else $error("register exclusive-or wrong");

  property p_mul_rng;
    resp_valid && c_r.op inside {icyc_pkg::ICYC_OP_UNSIGNED_MULTIPLY, icyc_pkg::ICYC_OP_SIGNED_MULTIPLY}
      |-> net >= 8'h26 && net <= 8'h46 && !net[0];
  endproperty
  a_mul_rng: assert property (p_mul_rng) else $error("multiply time out of range");

  property p_unsigned_multiply;
    resp_valid && c_r.op == icyc_pkg::ICYC_OP_UNSIGNED_MULTIPLY |-> net == 8'(38 + 2 * $countones(c_r.operand));
  endproperty
  a_unsigned_multiply: assert property (p_unsigned_multiply) else $error("unsigned multiply time wrong");

  property p_signed_multiply;
    resp_valid && c_r.op == icyc_pkg::ICYC_OP_SIGNED_MULTIPLY
      |-> net == 8'(38 + 2 * $countones(c_r.operand ^ {c_r.operand[14:0], 1'b0}));
  endproperty
  a_signed_multiply: assert property (p_signed_multiply) else $error("signed multiply time wrong");

  property p_div;
    resp_valid && c_r.src == icyc_pkg::ICYC_EA_DREG && c_r.op inside {icyc_pkg::ICYC_OP_SIGNED_DIVIDE,
      icyc_pkg::ICYC_OP_UNSIGNED_DIVIDE} |-> (c_r.op == icyc_pkg::ICYC_OP_SIGNED_DIVIDE)
        ? (net >= 8'h8f && net <= 8'h9e) : (net >= 8'h7f && net <= 8'h8c);
  endproperty
  a_div: assert property (p_div) else $error("divide time outside its band");

  c_signed_multiply: cover property (resp_valid && c_r.op == icyc_pkg::ICYC_OP_SIGNED_MULTIPLY);
  c_unsigned_divide: cover property (resp_valid && c_r.op == icyc_pkg::ICYC_OP_UNSIGNED_DIVIDE);
  c_wait: cover property (resp_valid && w_r != 8'h00);
endmodule // icyc_timing_props

bind icyc_timing icyc_timing_props u_props (
  .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .wait_clks(wait_clks), .resp_valid(resp_valid), .resp_r(resp_r)
);

`default_nettype wire

// ### testbench/icyc_mem_model.sv
// Memory side model: hands the timing block the wait clocks of slow memory.
// Assumes the bench sets the slow flag and the extra count before a request.
`default_nettype none

module icyc_mem_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic [7:0] extra,
  output var  logic [7:0] wait_clks
);
  // wait clocks added
  // Fast memory ends within the four-clock cycle, so it reports no wait.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_clks <= 8'h00;
    end else begin
      wait_clks <= slow ? extra : 8'h00;
    end
  end
endmodule // icyc_mem_model

`default_nettype wire

// ### testbench/icyc_timing_bench.sv
// Self-checking bench for the instruction cycle timing block.
// Assumes a 25 MHz clock; inputs change 1 ns after each rising edge.
`default_nettype none

module icyc_timing_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 req_valid = 1'b0;
  logic                 req_ready;
  icyc_pkg::icyc_req_s  req = '0;
  logic [7:0]           wait_clks;
  logic                 resp_valid;
  icyc_pkg::icyc_resp_s resp_r;
  logic                 slow = 1'b0;
  logic [7:0]           extra = 8'h00;
  icyc_pkg::icyc_resp_s got;
  int                   mismatches = 0;
  int                   n_tests = 0;

  always #20 clk_sys = ~clk_sys;

  icyc_timing i_dut (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wait_clks(wait_clks), .resp_valid(resp_valid), .resp_r(resp_r)
  );

  icyc_mem_model i_mem (
    .clk_sys(clk_sys), .rst(rst), .slow(slow), .extra(extra), .wait_clks(wait_clks)
  );

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_resp(input icyc_pkg::icyc_resp_s g, input icyc_pkg::icyc_resp_s e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic icyc_pkg::icyc_resp_s mk(input int c, input int r, input int w, input int i);
    return {8'(c), 3'(r), 3'(w), 1'(i)};
  endfunction

  // Address cost per mode; a long memory operand needs one more read and four more clocks.
  function automatic icyc_pkg::icyc_cost_s ea(input int m, input logic l);
    int c;
    case (m)
      0, 1: c = 0;
      2, 3, 11: c = 4;
      4: c = 6;
      6, 10: c = 10;
      8: c = 12;
      default: c = 8;
    endcase
    if (c != 0 && l)
      c += 4;
    return {8'(c), 3'(c / 4), 3'h0};
  endfunction

  function automatic icyc_pkg::icyc_req_s rq(input int op, input logic l, input int s, input int d,
                                             input int k, input logic [15:0] v);
    return {4'(op), l, 4'(s), 4'(d), 2'(k), v};
  endfunction

  task automatic tick(inout int n);
    if (n == 8) begin
      mismatches++;
      close_out;
    end else begin
      n++;
      @(posedge clk_sys);
      #1;
    end
  endtask

  // With junk set, a second request is held up while busy and must be ignored.
  task automatic issue(input icyc_pkg::icyc_req_s q, input logic junk);
    int n;
    @(posedge clk_sys);
    #1;
    req = q;
    req_valid = 1'b1;
    n = 0;
    while (!req_ready)
      tick(n);
    @(posedge clk_sys);
    #1;
    if (junk)
      req.op = icyc_pkg::ICYC_OP_SIGNED_DIVIDE;
    else
      req_valid = 1'b0;
    n = 0;
    while (!resp_valid)
      tick(n);
    got = resp_r;
    req_valid = 1'b0;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    chk_flag(req_ready, 1'b1);
    chk_flag(resp_valid, 1'b0);
    chk_resp(resp_r, mk(0, 0, 0, 0));
  endtask

  task automatic t_move_src;
    icyc_pkg::icyc_cost_s e;
    for (int m = 0; m < 12; m++) begin
      for (int l = 0; l < 2; l++) begin
        e = ea(m, l[0]);
        issue(rq(0, l[0], m, 0, 1, 16'h0000), 1'b0);
        chk_resp(got, mk(4 + e.clks, 1 + e.reads, 0, 0));
      end
    end
  endtask

  // The predecrement destination costs the same as the plain indirect one.
  task automatic t_move_dst;
    icyc_pkg::icyc_cost_s e;
    for (int m = 2; m < 9; m++) begin
      for (int l = 0; l < 2; l++) begin
        e = ea(m == 4 ? 2 : m, 1'b0);
        issue(rq(0, l[0], 0, m, 2, 16'h0000), 1'b0);
        chk_resp(got, mk((l ? 8 : 4) + e.clks, e.reads, 1 + l, 0));
      end
    end
  endtask

  task automatic t_std;
    for (int o = 1; o < 5; o++) begin
      issue(rq(o, 1'b1, 0, 0, 1, 16'h0000), 1'b0);
      chk_resp(got, mk(8, 1, 0, 0));
      issue(rq(o, 1'b0, 2, 0, 1, 16'h0000), 1'b0);
      chk_resp(got, mk(8, 2, 0, 0));
      issue(rq(o, 1'b1, 5, 0, 1, 16'h0000), 1'b0);
      chk_resp(got, mk(18, 4, 0, 0));
    end
    issue(rq(1, 1'b0, 1, 0, 1, 16'h0000), 1'b0);
    chk_resp(got, mk(4, 1, 0, 0));
    issue(rq(1, 1'b0, 0, 0, 0, 16'h0000), 1'b0);
    chk_resp(got, mk(8, 1, 0, 0));
    issue(rq(5, 1'b0, 0, 0, 0, 16'h0000), 1'b0);
    chk_resp(got, mk(6, 1, 0, 0));
    issue(rq(5, 1'b1, 0, 0, 1, 16'h0000), 1'b0);
    chk_resp(got, mk(6, 1, 0, 0));
    issue(rq(1, 1'b1, 11, 0, 1, 16'h0000), 1'b0);
    chk_resp(got, mk(8, 1, 0, 0));
    issue(rq(1, 1'b1, 2, 0, 2, 16'h0000), 1'b0);
    chk_resp(got, mk(20, 3, 2, 0));
    issue(rq(5, 1'b0, 2, 0, 2, 16'h0000), 1'b0);
    chk_flag(got.illegal, 1'b1);
    issue(rq(6, 1'b0, 2, 0, 2, 16'h0000), 1'b0);
    chk_resp(got, mk(12, 2, 1, 0));
    issue(rq(11, 1'b1, 0, 0, 1, 16'h0000), 1'b0);
    chk_resp(got, mk(6, 1, 0, 0));
    issue(rq(12, 1'b0, 2, 0, 2, 16'h0000), 1'b0);
    chk_resp(got, mk(12, 2, 1, 0));
    issue(rq(13, 1'b1, 2, 0, 1, 16'h0000), 1'b0);
    chk_resp(got, mk(12, 3, 0, 0));
    for (int l = 0; l < 2; l++) begin
      issue(rq(6, l[0], 0, 0, 1, 16'h0000), 1'b0);
      chk_resp(got, mk(l ? 8 : 4, 1, 0, 0));
    end
    issue(rq(6, 1'b0, 2, 0, 1, 16'h0000), 1'b0);
    chk_flag(got.illegal, 1'b1);
  endtask

  task automatic t_mul;
    logic [15:0] v[4] = '{16'h0000, 16'hffff, 16'h5555, 16'h0001};
    int          eu[4] = '{38, 70, 54, 40};
    int          es[4] = '{38, 40, 70, 42};
    for (int i = 0; i < 4; i++) begin
      issue(rq(7, 1'b0, 0, 0, 1, v[i]), 1'b0);
      chk_resp(got, mk(eu[i], 1, 0, 0));
      issue(rq(8, 1'b0, 0, 0, 1, v[i]), 1'b0);
      chk_resp(got, mk(es[i], 1, 0, 0));
    end
  endtask

  task automatic t_div;
    issue(rq(10, 1'b0, 0, 0, 1, 16'h0000), 1'b0);
    chk_resp(got, mk(143, 1, 0, 0));
    issue(rq(10, 1'b0, 0, 0, 1, 16'hffff), 1'b0);
    chk_resp(got, mk(158, 1, 0, 0));
    issue(rq(9, 1'b0, 0, 0, 1, 16'h0000), 1'b0);
    chk_resp(got, mk(127, 1, 0, 0));
    issue(rq(9, 1'b0, 0, 0, 1, 16'hffff), 1'b0);
    chk_resp(got, mk(140, 1, 0, 0));
  endtask

  task automatic t_wait;
    slow = 1'b1;
    extra = 8'h07;
    issue(rq(0, 1'b0, 0, 0, 1, 16'h0000), 1'b1);
    chk_resp(got, mk(11, 1, 0, 0));
    @(posedge clk_sys);
    #1;
    chk_flag(resp_valid, 1'b0);
    chk_resp(resp_r, mk(11, 1, 0, 0));
    slow = 1'b0;
    extra = 8'h00;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset;
    t_move_src;
    t_move_dst;
    t_std;
    t_mul;
    t_div;
    t_wait;
    close_out;
  end
endmodule // icyc_timing_bench

`default_nettype wire
